// *** hw/dmc_defines.svh ***
// Register offsets, field positions, reset values and counts of the DMA controller
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

// ------------------------------------------------------------
// Register map: channel n at byte 0x20*n, register offset below
// ------------------------------------------------------------
`define DMC_OFF_SRC    5'h00
`define DMC_OFF_SRCC   5'h04
`define DMC_OFF_DST    5'h08
`define DMC_OFF_DSTC   5'h0C
`define DMC_OFF_CTRL   5'h10
`define DMC_OFF_STAT   5'h14
`define DMC_OFF_TRIG   5'h18

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define DMC_CTRL_TC_MSB  19
`define DMC_CTRL_SEL_LSB 20
`define DMC_CTRL_HW      23
`define DMC_CTRL_DSZ_LSB 24
`define DMC_CTRL_BURST   26
`define DMC_CTRL_WHOLE   27
`define DMC_CTRL_HSHK    28
`define DMC_CTRL_INTEN   29
`define DMC_CFG_FIXED    0
`define DMC_CFG_LOC      1
`define DMC_TRIG_SW      0
`define DMC_TRIG_ON      1

// ------------------------------------------------------------
// Reset values and counts
// ------------------------------------------------------------
`define DMC_RST_WORD     32'h0000_0000
`define DMC_BURST_LAST   2'h3
`define DMC_NUM_SRC      5

`endif

// *** hw/dmc_pkg.sv ***
// Types of the DMA controller
package dmc_pkg;
   typedef logic [31:0] dmc_word_t;

   typedef enum logic [1:0] {
      CH_IDLE = 2'b00,
      CH_LOAD = 2'b01,
      CH_XFER = 2'b10,
      CH_HOLD = 2'b11
   } dmc_ch_e;

   typedef enum logic [1:0] {
      SB_IDLE = 2'b00,
      SB_RD   = 2'b01,
      SB_WR   = 2'b10
   } dmc_sub_e;

   typedef struct packed {
      dmc_ch_e     state;
      logic [19:0] cur_tc;
      dmc_word_t   cur_src;
      dmc_word_t   cur_dst;
      dmc_word_t   isrc;
      dmc_word_t   idst;
      logic [1:0]  src_cfg;
      logic [1:0]  dst_cfg;
      dmc_word_t   ctrl;
      logic        on;
      logic        swreq;
   } dmc_ch_s;

   typedef struct packed {
      dmc_ch_s [3:0]   ch;
      logic [1:0]      sync1;
      logic [1:0]      sync2;
      logic [1:0]      ack_n;
      logic [3:0]      irq;
      dmc_sub_e        sb;
      logic [1:0]      own;
      logic [1:0]      beat;
      dmc_word_t [3:0] dbuf;
      dmc_word_t       m_address;
      dmc_word_t       m_wdata;
      logic            m_read;
      logic            m_write;
      logic            m_sel;
      logic [1:0]      m_size;
      logic            m_req;
      logic            avs_wait;
      dmc_word_t       avs_rdata;
   } dmc_state_s;
endpackage

// *** hw/dmc_top.sv ***
// Four-channel DMA controller with register slave and data mover master
`timescale 1ns/100ps
`include "dmc_defines.svh"

module dmc_top #(
   parameter int NCH  = 4,
   parameter int NSRC = 5
) (
   // Clock and reset
   input  wire logic               mclk,
   input  wire logic               rst_n,
   // Register slave
   input  wire logic [6:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire dmc_pkg::dmc_word_t avs_writedata,
   output dmc_pkg::dmc_word_t      avs_readdata,
   output logic                    avs_waitrequest,
   // Data mover master
   output dmc_pkg::dmc_word_t      m_address,
   output logic                    m_read,
   output logic                    m_write,
   output dmc_pkg::dmc_word_t      m_writedata,
   input  wire dmc_pkg::dmc_word_t m_readdata,
   input  wire logic               m_waitrequest,
   output logic [1:0]              m_size,
   output logic                    m_bus_sel,
   output logic                    m_bus_req,
   input  wire logic               m_bus_grant,
   // Request sources and answers
   input  wire logic [19:0]        periph_req,
   input  wire logic               ext_request_zero_n,
   input  wire logic               ext_request_one_n,
   output logic [1:0]              ext_acknowledge_pin_n,
   output logic [3:0]              irq_req
);
   import dmc_pkg::*;

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (NCH != 4 || NSRC != `DMC_NUM_SRC) begin : g_chk
      $error("dmc_top serves four channels of five sources only");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   dmc_state_s s_r;
   dmc_state_s s_nxt;
   logic       chunk_done;
   logic [1:0] last;
   logic [1:0] dsz;
   logic [1:0] nb;
   logic [2:0] sel;
   logic       ext;
   logic       hreq;
   logic       req;
   logic       found;
   logic [4:0] ro;
   logic [1:0] ci;
   dmc_word_t  step;

   // Next-state logic of bus slave, channels and data mover
   always_comb begin
      s_nxt = s_r;
      chunk_done = 1'b0;
      found = 1'b0;
      ext = 1'b0;
      hreq = 1'b0;
      req = 1'b0;
      sel = 3'h0;
      ro = avs_address[4:0];
      ci = avs_address[6:5];
      dsz = s_r.ch[s_r.own].ctrl[`DMC_CTRL_DSZ_LSB+:2];
      last = s_r.ch[s_r.own].ctrl[`DMC_CTRL_BURST] ? `DMC_BURST_LAST : 2'h0;
      nb = s_r.beat + 2'h1;
      step = {30'h0, last + 2'h0} + 32'h1;
      step = step << dsz;
      s_nxt.sync1 = {ext_request_one_n, ext_request_zero_n};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.irq = 4'h0;
      s_nxt.avs_wait = 1'b1;

      // Main FSM of each channel
      for (int c = 0; c < 4; c++) begin
         sel = s_r.ch[c].ctrl[`DMC_CTRL_SEL_LSB+:3];
         ext = (c < 2) && (sel == 3'h0);
         if (ext) begin
            hreq = !s_r.sync2[c];
         end else if (sel < 3'h5) begin
            hreq = periph_req[c*5+int'(sel)];
         end else begin
            hreq = 1'b0;
         end
         req = s_r.ch[c].ctrl[`DMC_CTRL_HW] ? (hreq && s_r.ch[c].on) : s_r.ch[c].swreq;
         case (s_r.ch[c].state)
            CH_IDLE: begin
               if (req) begin
                  s_nxt.ch[c].state = CH_LOAD;
                  s_nxt.ch[c].swreq = 1'b0;
               end
            end
            CH_LOAD: begin
               if (s_r.ch[c].cur_tc == 20'h0) begin
                  s_nxt.ch[c].cur_tc = s_r.ch[c].ctrl[`DMC_CTRL_TC_MSB:0];
                  s_nxt.ch[c].cur_src = s_r.ch[c].isrc;
                  s_nxt.ch[c].cur_dst = s_r.ch[c].idst;
               end
               s_nxt.ch[c].state = CH_XFER;
            end
            CH_XFER: begin
               s_nxt.ch[c].state = CH_XFER;
            end
            CH_HOLD: begin
               // Handshake keeps acknowledge until the request is released
               if (!(ext && s_r.ch[c].ctrl[`DMC_CTRL_HSHK]) || s_r.sync2[c]) begin
                  s_nxt.ch[c].state = CH_IDLE;
               end
            end
            default: s_nxt.ch[c].state = CH_IDLE;
         endcase
      end

      // Sub-FSM: one chunk of reads then writes under bus ownership
      case (s_r.sb)
         SB_IDLE: begin
            if (s_r.m_req && m_bus_grant) begin
               s_nxt.sb = SB_RD;
               s_nxt.beat = 2'h0;
               s_nxt.m_read = 1'b1;
               s_nxt.m_address = s_r.ch[s_r.own].cur_src;
               s_nxt.m_sel = s_r.ch[s_r.own].src_cfg[`DMC_CFG_LOC];
               s_nxt.m_size = dsz;
            end else if (!s_r.m_req) begin
               for (int c = 3; c >= 0; c--) begin
                  if (s_r.ch[c].state == CH_XFER) begin
                     s_nxt.own = 2'(c);
                     found = 1'b1;
                  end
               end
               s_nxt.m_req = found;
            end
         end
         SB_RD: begin
            if (!m_waitrequest) begin
               s_nxt.dbuf[s_r.beat] = m_readdata;
               if (s_r.beat == last) begin
                  s_nxt.sb = SB_WR;
                  s_nxt.beat = 2'h0;
                  s_nxt.m_read = 1'b0;
                  s_nxt.m_write = 1'b1;
                  s_nxt.m_address = s_r.ch[s_r.own].cur_dst;
                  s_nxt.m_sel = s_r.ch[s_r.own].dst_cfg[`DMC_CFG_LOC];
                  s_nxt.m_wdata = (last == 2'h0) ? m_readdata : s_r.dbuf[0];
               end else begin
                  s_nxt.beat = nb;
                  s_nxt.m_address = s_r.ch[s_r.own].cur_src + ({30'h0, nb} << dsz);
               end
            end
         end
         SB_WR: begin
            if (!m_waitrequest) begin
               if (s_r.beat == last) begin
                  s_nxt.sb = SB_IDLE;
                  s_nxt.m_write = 1'b0;
                  s_nxt.m_req = 1'b0;
                  chunk_done = 1'b1;
               end else begin
                  s_nxt.beat = nb;
                  s_nxt.m_address = s_r.ch[s_r.own].cur_dst + ({30'h0, nb} << dsz);
                  s_nxt.m_wdata = s_r.dbuf[nb];
               end
            end
         end
         default: s_nxt.sb = SB_IDLE;
      endcase

      // End of chunk: count, addresses, service mode decision
      if (chunk_done) begin
         sel = s_r.ch[s_r.own].ctrl[`DMC_CTRL_SEL_LSB+:3];
         ext = (s_r.own < 2'h2) && (sel == 3'h0);
         if (!s_r.ch[s_r.own].src_cfg[`DMC_CFG_FIXED]) begin
            s_nxt.ch[s_r.own].cur_src = s_r.ch[s_r.own].cur_src + step;
         end
         if (!s_r.ch[s_r.own].dst_cfg[`DMC_CFG_FIXED]) begin
            s_nxt.ch[s_r.own].cur_dst = s_r.ch[s_r.own].cur_dst + step;
         end
         if (s_r.ch[s_r.own].cur_tc <= 20'h1) begin
            s_nxt.ch[s_r.own].cur_tc = 20'h0;
            s_nxt.ch[s_r.own].on = 1'b0;
            s_nxt.ch[s_r.own].state = CH_HOLD;
            s_nxt.irq[s_r.own] = s_r.ch[s_r.own].ctrl[`DMC_CTRL_INTEN];
         end else begin
            s_nxt.ch[s_r.own].cur_tc = s_r.ch[s_r.own].cur_tc - 20'h1;
            if (s_r.ch[s_r.own].ctrl[`DMC_CTRL_WHOLE]) begin
               s_nxt.ch[s_r.own].state = CH_XFER;
            end else if (ext && s_r.ch[s_r.own].ctrl[`DMC_CTRL_HSHK]) begin
               s_nxt.ch[s_r.own].state = CH_HOLD;
            end else begin
               s_nxt.ch[s_r.own].state = CH_IDLE;
            end
         end
      end

      // Register slave: answer one cycle after the request is seen
      if ((avs_read || avs_write) && s_r.avs_wait) begin
         s_nxt.avs_wait = 1'b0;
         if (ro == `DMC_OFF_SRC) begin
            s_nxt.avs_rdata = s_r.ch[ci].isrc;
         end else if (ro == `DMC_OFF_SRCC) begin
            s_nxt.avs_rdata = {30'h0, s_r.ch[ci].src_cfg};
         end else if (ro == `DMC_OFF_DST) begin
            s_nxt.avs_rdata = s_r.ch[ci].idst;
         end else if (ro == `DMC_OFF_DSTC) begin
            s_nxt.avs_rdata = {30'h0, s_r.ch[ci].dst_cfg};
         end else if (ro == `DMC_OFF_CTRL) begin
            s_nxt.avs_rdata = s_r.ch[ci].ctrl;
         end else if (ro == `DMC_OFF_STAT) begin
            s_nxt.avs_rdata = {10'h000, s_r.ch[ci].state, s_r.ch[ci].cur_tc};
         end else if (ro == `DMC_OFF_TRIG) begin
            s_nxt.avs_rdata = {30'h0, s_r.ch[ci].on, s_r.ch[ci].swreq};
         end else begin
            s_nxt.avs_rdata = `DMC_RST_WORD;
         end
      end

      // Writes take effect on the accepting edge; software set wins
      if (avs_write && !s_r.avs_wait) begin
         if (ro == `DMC_OFF_SRC) begin
            s_nxt.ch[ci].isrc = avs_writedata;
         end else if (ro == `DMC_OFF_SRCC) begin
            s_nxt.ch[ci].src_cfg = avs_writedata[1:0];
         end else if (ro == `DMC_OFF_DST) begin
            s_nxt.ch[ci].idst = avs_writedata;
         end else if (ro == `DMC_OFF_DSTC) begin
            s_nxt.ch[ci].dst_cfg = avs_writedata[1:0];
         end else if (ro == `DMC_OFF_CTRL) begin
            s_nxt.ch[ci].ctrl = avs_writedata;
         end else if (ro == `DMC_OFF_TRIG) begin
            s_nxt.ch[ci].on = avs_writedata[`DMC_TRIG_ON];
            s_nxt.ch[ci].swreq = s_nxt.ch[ci].swreq | avs_writedata[`DMC_TRIG_SW];
         end
      end

      // External acknowledge follows the next state of channels 0 and 1
      for (int c = 0; c < 2; c++) begin
         sel = s_nxt.ch[c].ctrl[`DMC_CTRL_SEL_LSB+:3];
         s_nxt.ack_n[c] = !((sel == 3'h0) && (s_nxt.ch[c].state != CH_IDLE));
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.sync1 <= 2'h3;
         s_r.sync2 <= 2'h3;
         s_r.ack_n <= 2'h3;
         s_r.avs_wait <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state register
   assign avs_readdata = s_r.avs_rdata;
   assign avs_waitrequest = s_r.avs_wait;
   assign m_address = s_r.m_address;
   assign m_read = s_r.m_read;
   assign m_write = s_r.m_write;
   assign m_writedata = s_r.m_wdata;
   assign m_size = s_r.m_size;
   assign m_bus_sel = s_r.m_sel;
   assign m_bus_req = s_r.m_req;
   assign ext_acknowledge_pin_n = s_r.ack_n;
   assign irq_req = s_r.irq;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_rel;
      s_r.ch[0].state == CH_HOLD && ext_request_zero_n && s_r.ch[0].ctrl[`DMC_CTRL_HSHK];
   endsequence
   sequence s_last_rd;
      m_read && !m_waitrequest && s_r.beat == last;
   endsequence

   property p_idle_quiet;
      s_r.ch[0].state == CH_IDLE |-> !irq_req[0] && (ext_acknowledge_pin_n[0] || s_r.ch[0].ctrl[22:20] != 3'h0);
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("idle channel drives ack or irq");

   property p_load_tc;
      s_r.ch[0].state == CH_LOAD && s_r.ch[0].cur_tc == 20'h0 |=> s_r.ch[0].cur_tc == $past(s_r.ch[0].ctrl[19:0]);
   endproperty
   a_load_tc: assert property (p_load_tc) else $error("count not loaded");

   property p_dec;
      chunk_done && s_r.own == 2'h0 && s_r.ch[0].cur_tc > 20'h1
         |=> s_r.ch[0].cur_tc == $past(s_r.ch[0].cur_tc) - 20'h1;
   endproperty
   a_dec: assert property (p_dec) else $error("count not decremented");

   property p_irq;
      irq_req[0] |-> $past(chunk_done) && $past(s_r.ch[0].ctrl[`DMC_CTRL_INTEN]) && s_r.ch[0].cur_tc == 20'h0;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without count zero");

   property p_sync;
      $fell(ext_acknowledge_pin_n[0]) && s_r.ch[0].ctrl[`DMC_CTRL_HW] |-> !$past(ext_request_zero_n, 3);
   endproperty
   a_sync: assert property (p_sync) else $error("ack before two sync stages");

   property p_hshk;
      s_rel |-> ##[1:4] ext_acknowledge_pin_n[0];
   endproperty
   a_hshk: assert property (p_hshk) else $error("ack not released");

   property p_own;
      (m_read || m_write) |-> m_bus_req;
   endproperty
   a_own: assert property (p_own) else $error("bus access without ownership");

   property p_rd_wr;
      s_last_rd |=> m_write && !m_read;
   endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("write does not follow reads");

   property p_single;
      chunk_done && s_r.own == 2'h0 && !s_r.ch[0].ctrl[`DMC_CTRL_WHOLE] |=> s_r.ch[0].state != CH_XFER;
   endproperty
   a_single: assert property (p_single) else $error("single service kept running");
endmodule

// *** testbench/dmc_mem_model.sv ***
// Memory slave and bus arbiter that answer the DMA mover
`timescale 1ns/100ps
module dmc_mem_model (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Mover bus
   input  wire logic [31:0] m_address,
   input  wire logic        m_read,
   input  wire logic        m_write,
   input  wire logic [31:0] m_writedata,
   output logic [31:0]      m_readdata,
   output logic             m_waitrequest,
   input  wire logic        m_bus_req,
   output logic             m_bus_grant,
   // Pace and monitor
   input  wire logic        slow,
   output logic [15:0]      wr_cnt
);
   logic [31:0] mem [0:63];
   logic [31:0] last_r;
   logic [1:0]  cnt_r;
   logic        ans;

   // Each beat answered after zero or two wait cycles
   assign ans           = (m_read | m_write) && (cnt_r == (slow ? 2'h2 : 2'h0));
   assign m_waitrequest = !ans;
   // Idle data lines show the inverse of the last latched value, which after an odd number of write beats is the last read data
   assign m_readdata    = (m_read && ans) ? mem[m_address[7:2]] : ~last_r;

   // Recognisable preload pattern
   initial begin
      for (int i = 0; i < 64; i++) begin
         mem[i] = 32'hC0DE_0000 + 32'(i);
      end
   end

   // Grant follows request one cycle late, beats served in order
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r       <= 2'h0;
         m_bus_grant <= 1'b0;
         last_r      <= 32'h0;
         wr_cnt      <= 16'h0;
      end else begin
         m_bus_grant <= m_bus_req;
         if (ans) begin
            cnt_r  <= 2'h0;
            last_r <= m_readdata;
            if (m_write) begin
               mem[m_address[7:2]] <= m_writedata;
               wr_cnt              <= wr_cnt + 16'h1;
            end
         end else if (m_read | m_write) begin
            cnt_r <= cnt_r + 2'h1;
         end
      end
   end
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the four-channel DMA controller
`timescale 1ns/100ps
`include "dmc_defines.svh"
module testbench;
   import dmc_pkg::*;
   typedef struct packed {
      logic [1:0] ch;
      logic       burst;
      logic       fixed;
      logic [3:0] cnt;
      logic [5:0] src;
      logic [5:0] dst;
      logic       inten;
      logic       slow;
   } dmc_row_s;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [6:0]  avs_address = 7'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   dmc_word_t   avs_writedata = 32'h0;
   dmc_word_t   avs_readdata, m_address, m_writedata, m_readdata, q;
   logic        avs_waitrequest, m_read, m_write, m_waitrequest, m_bus_sel, m_bus_req, m_bus_grant;
   logic [1:0]  m_size, ack_n;
   logic [1:0]  ext_n = 2'h3;
   logic [19:0] periph_req = 20'h0;
   logic [3:0]  irq_req;
   logic        slow = 1'b0;
   logic [1:0]  loc_exp = 2'h0;
   logic [15:0] wr_cnt;
   int          irq_cnt [4] = '{0, 0, 0, 0};
   int          fail_count = 0;
   int          tests_run = 0;
   // Rows: channel, burst, fixed source, count, source, destination, irq enable, slow slave
   dmc_row_s    rows [5] = '{'{0, 0, 0, 2, 0, 32, 1, 0}, '{1, 1, 0, 1, 4, 36, 1, 1},
                             '{2, 1, 1, 1, 8, 44, 1, 0}, '{3, 0, 1, 3, 12, 48, 0, 1},
                             '{0, 1, 0, 2, 16, 52, 1, 1}};

   // Clock, irq pulse counting and mover size and bus select check
   always #25 mclk = ~mclk;
   always @(posedge mclk) begin
      for (int i = 0; i < 4; i++) begin
         if (irq_req[i] === 1'b1) begin
            irq_cnt[i]++;
         end
      end
      if (m_read === 1'b1 || m_write === 1'b1) begin
         chk({29'h0, 2'h2, m_read ? loc_exp[1] : loc_exp[0]}, {29'h0, m_size, m_bus_sel});
      end
   end

   // ------------------------------------------------------------
   // Design and far side
   // ------------------------------------------------------------
   dmc_top uut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .m_address(m_address), .m_read(m_read), .m_write(m_write),
      .m_writedata(m_writedata), .m_readdata(m_readdata), .m_waitrequest(m_waitrequest), .m_size(m_size),
      .m_bus_sel(m_bus_sel), .m_bus_req(m_bus_req), .m_bus_grant(m_bus_grant), .periph_req(periph_req),
      .ext_request_zero_n(ext_n[0]), .ext_request_one_n(ext_n[1]), .ext_acknowledge_pin_n(ack_n),
      .irq_req(irq_req));
   dmc_mem_model slave (.mclk(mclk), .rst_n(rst_n), .m_address(m_address), .m_read(m_read),
      .m_write(m_write), .m_writedata(m_writedata), .m_readdata(m_readdata), .m_waitrequest(m_waitrequest),
      .m_bus_req(m_bus_req), .m_bus_grant(m_bus_grant), .slow(slow), .wr_cnt(wr_cnt));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input dmc_word_t e, input dmc_word_t g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected at %0t ns: expected %h got %h", $time, e, g);
      end
   endtask

   task automatic tmo(input int n);
      chk(32'(n < 2000), 32'h1);
      if (n >= 2000) begin
         report_and_stop();
      end
   endtask

   // Register access, held until waitrequest is seen low at an edge
   task automatic av(input logic wr, input logic [1:0] c, input logic [4:0] off, input dmc_word_t d);
      int n;
      n = 0;
      avs_address   <= {c, off};
      avs_writedata <= d;
      avs_read      <= ~wr;
      avs_write     <= wr;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 2000);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      tmo(n);
      @(posedge mclk);
   endtask

   function automatic dmc_word_t ctl(input logic ie, hs, wh, bu, hw, input logic [2:0] sel, input logic [19:0] tc);
      return {2'h0, ie, hs, wh, bu, 2'h2, hw, sel, tc};
   endfunction

   task automatic prog(input logic [1:0] c, input logic [5:0] s, input logic fx, input logic [5:0] d,
                       input dmc_word_t cw);
      av(1'b1, c, `DMC_OFF_SRC, {24'h0, s, 2'h0});
      av(1'b1, c, `DMC_OFF_SRCC, {31'h0, fx});
      av(1'b1, c, `DMC_OFF_DST, {24'h0, d, 2'h0});
      av(1'b1, c, `DMC_OFF_DSTC, 32'h0);
      av(1'b1, c, `DMC_OFF_CTRL, cw);
   endtask

   // Wait for the writes, then for the channel to report idle with count zero
   task automatic wait_done(input logic [1:0] c, input logic [15:0] tgt);
      int n;
      n = 0;
      while (wr_cnt !== tgt && n < 2000) begin
         @(posedge mclk);
         n++;
      end
      tmo(n);
      do begin
         av(1'b0, c, `DMC_OFF_STAT, 32'h0);
         n++;
      end while (q !== 32'h0 && n < 2000);
      tmo(n);
   endtask

   task automatic chk_mem(input int s, input int d, input int n, input logic bu, input logic fx);
      for (int j = 0; j < n; j++) begin
         chk(32'hC0DE_0000 + 32'(s + (fx ? (bu ? j % 4 : 0) : j)), slave.mem[d + j]);
      end
   endtask

   // External requester run: one unit per request, or both units on one request
   task automatic ext_run(input logic [1:0] c, input logic hs, input logic wh, input logic [5:0] s);
      int n, k, nr, i0;
      logic [15:0] w;
      nr = (hs && !wh) ? 2 : 1;
      prog(c, s, 1'b0, 6'd60, ctl(1'b1, hs, wh, 1'b0, 1'b1, 3'h0, 20'h2));
      av(1'b1, c, `DMC_OFF_TRIG, 32'h2);
      i0 = irq_cnt[c];
      for (k = 0; k < nr; k++) begin
         w = wr_cnt + 16'(2 / nr);
         ext_n[c] <= 1'b0;
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (ack_n[c] !== 1'b0 && n < 20);
         chk(32'(n >= 4 && n <= 5), 32'h1);
         while (wr_cnt !== w && n < 2000) begin
            @(posedge mclk);
            n++;
         end
         tmo(n);
         if (hs && !wh) begin
            av(1'b0, c, `DMC_OFF_STAT, 32'h0);
            if (k == 0) begin
               chk(32'h0030_0001, q);
            end
            chk(32'(ack_n[c]), 32'h0);
         end
         ext_n[c] <= 1'b1;
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (ack_n[c] !== 1'b1 && n < 20);
         chk(32'(n <= 5), 32'h1);
      end
      wait_done(c, wr_cnt);
      chk(32'(irq_cnt[c] - i0), 32'h1);
      chk_mem(s, 60, 2, 1'b0, 1'b0);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      int i0, nw;
      logic [15:0] w;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      // Software-started whole-service transfers on every channel
      foreach (rows[r]) begin
         slow <= rows[r].slow;
         prog(rows[r].ch, rows[r].src, rows[r].fixed, rows[r].dst,
              ctl(rows[r].inten, 1'b0, 1'b1, rows[r].burst, 1'b0, 3'h0, 20'(rows[r].cnt)));
         nw = rows[r].cnt * (rows[r].burst ? 4 : 1);
         w  = wr_cnt + 16'(nw);
         i0 = irq_cnt[rows[r].ch];
         av(1'b1, rows[r].ch, `DMC_OFF_TRIG, 32'h1);
         wait_done(rows[r].ch, w);
         chk(32'(irq_cnt[rows[r].ch] - i0), 32'(rows[r].inten));
         chk_mem(rows[r].src, rows[r].dst, nw, rows[r].burst, rows[r].fixed);
      end
      // Peripheral request ignored in software mode, served in hardware mode
      slow <= 1'b0;
      prog(2'd2, 6'd24, 1'b0, 6'd62, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 3'h1, 20'h1));
      av(1'b1, 2'd2, `DMC_OFF_SRCC, 32'h2);
      loc_exp <= 2'h2;
      w = wr_cnt;
      periph_req <= 20'h00800;
      av(1'b1, 2'd2, `DMC_OFF_TRIG, 32'h2);
      repeat (20) @(posedge mclk);
      chk(32'(wr_cnt), 32'(w));
      av(1'b1, 2'd2, `DMC_OFF_CTRL, ctl(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 3'h1, 20'h1));
      wait_done(2'd2, w + 16'h1);
      periph_req <= 20'h0;
      loc_exp <= 2'h0;
      chk_mem(24, 62, 1, 1'b0, 1'b0);
      // External protocols: single handshake, single demand, whole handshake
      ext_run(2'd0, 1'b1, 1'b0, 6'd26);
      ext_run(2'd1, 1'b0, 1'b0, 6'd28);
      ext_run(2'd0, 1'b1, 1'b1, 6'd30);
      // Reset in mid-transfer
      slow <= 1'b1;
      prog(2'd0, 6'd0, 1'b0, 6'd40, ctl(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 3'h0, 20'h8));
      av(1'b1, 2'd0, `DMC_OFF_TRIG, 32'h1);
      repeat (6) @(posedge mclk);
      rst_n <= 1'b0;
      repeat (6) @(posedge mclk);
      chk(32'h031, 32'({irq_req, ack_n, m_bus_req, m_read, m_write, avs_waitrequest}));
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int c = 0; c < 4; c++) begin
         av(1'b0, 2'(c), `DMC_OFF_STAT, 32'h0);
         chk(q, 32'h0);
      end
      av(1'b0, 2'd0, `DMC_OFF_CTRL, 32'h0);
      chk(q, `DMC_RST_WORD);
      av(1'b0, 2'd3, 5'h1C, 32'h0);
      chk(q, 32'h0);
      report_and_stop();
   end
endmodule
